// ===== design/vt_device.sv
`timescale 1ns/10ps
`default_nettype none
module vt_device
  import vt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic adc_done_i,
  output logic busy_o,
  output logic vt_done_o,
  vt_port_if.device link
);
  logic rst;
  logic wr_take, rd_first, flags_read, ev_adc, ev_vt, ev_any, finish;

  // Port access
  logic wr_low_ff, nxt_wr_low, rd_low_ff, nxt_rd_low, rdata_oe_ff, nxt_rdata_oe;
  logic [3:0] lat_addr_ff, nxt_lat_addr;
  logic [11:0] lat_data_ff, nxt_lat_data, rdata_ff, nxt_rdata, ctrl_ff, nxt_ctrl;
  logic signed [11:0] phase_one_input_ff, nxt_phase_one_input;
  logic signed [11:0] phase_two_input_ff, nxt_phase_two_input;
  logic signed [11:0] phase_three_input_ff, nxt_phase_three_input;
  logic signed [11:0] direct_voltage_in, quadrature_voltage_in;

  // Engine
  vt_mode_t mode_ff, nxt_mode;
  logic last_fwd_ff, nxt_last_fwd, busy_ff, nxt_busy, done_ff, nxt_done;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [1:0] quad_ff, nxt_quad;
  logic signed [15:0] cx_ff, nxt_cx, cy_ff, nxt_cy, cos_v, sin_v, dx, dy;
  logic signed [11:0] cz_ff, nxt_cz;
  logic signed [11:0] wx_ff, nxt_wx, wy_ff, nxt_wy, wa_ff, nxt_wa, wb_ff, nxt_wb;
  logic signed [12:0] ph_sum, ph_diff;
  logic signed [27:0] xc, ys, yc, xs;
  logic signed [28:0] y_prod, half_a, k_b;
  logic signed [11:0] x_current_result_ff, nxt_x_current_result;
  logic signed [11:0] y_current_result_ff, nxt_y_current_result;
  logic signed [11:0] direct_current_result_ff, nxt_direct_current_result;
  logic signed [11:0] quadrature_current_result_ff, nxt_quadrature_current_result;
  logic signed [11:0] x_voltage_result_ff, nxt_x_voltage_result;
  logic signed [11:0] y_voltage_result_ff, nxt_y_voltage_result;
  logic signed [11:0] phase_two_output_ff, nxt_phase_two_output;
  logic signed [11:0] phase_three_output_ff, nxt_phase_three_output;

  // Interrupt
  logic [2:0] flags_ff, nxt_flags;
  logic irq_hold_ff, nxt_irq_hold, irq_oe_ff, nxt_irq_oe;

  // Either reset source, both sampled on the clock
  assign rst = !reset_n_i || !link.dev_reset_n;
  assign direct_voltage_in = phase_one_input_ff;
  assign quadrature_voltage_in = phase_two_input_ff;

  // Data taken on the rising edge of the write strobe
  assign wr_take = wr_low_ff && link.wr_n;
  assign rd_first = !link.cs_n && !link.rd_n && !rd_low_ff;
  assign flags_read = rd_first && (link.addr == ADDR_SYS_FLAGS);

  always_comb begin
    nxt_wr_low = !link.cs_n && !link.wr_n;
    nxt_lat_addr = nxt_wr_low ? link.addr : lat_addr_ff;
    nxt_lat_data = nxt_wr_low ? link.data_bus : lat_data_ff;
    nxt_rd_low = !link.cs_n && !link.rd_n;
    nxt_rdata_oe = nxt_rd_low;
    nxt_ctrl = ctrl_ff;
    nxt_phase_one_input = phase_one_input_ff;
    nxt_phase_two_input = phase_two_input_ff;
    nxt_phase_three_input = phase_three_input_ff;
    if (wr_take) begin
      case (lat_addr_ff)
        ADDR_PH1_VD: nxt_phase_one_input = lat_data_ff;
        ADDR_PH2_VQ: nxt_phase_two_input = lat_data_ff;
        ADDR_PH3: nxt_phase_three_input = lat_data_ff;
        ADDR_SYS_CTRL: nxt_ctrl = lat_data_ff;
        default: ;
      endcase
    end
    nxt_rdata = rdata_ff;
    if (rd_first) begin
      case (link.addr)
        ADDR_RES0: nxt_rdata = last_fwd_ff ? x_voltage_result_ff : direct_current_result_ff;
        ADDR_RES1: nxt_rdata = last_fwd_ff ? phase_two_output_ff : quadrature_current_result_ff;
        ADDR_RES2: nxt_rdata = last_fwd_ff ? phase_three_output_ff : x_current_result_ff;
        ADDR_RES3: nxt_rdata = last_fwd_ff ? y_voltage_result_ff : y_current_result_ff;
        ADDR_SYS_FLAGS: begin
          nxt_rdata = 12'h000;
          nxt_rdata[FLAG_ANY_BIT] = flags_ff[2];
          nxt_rdata[FLAG_VT_BIT] = flags_ff[1];
          nxt_rdata[FLAG_ADC_BIT] = flags_ff[0];
        end
        default: nxt_rdata = 12'h000;
      endcase
    end
  end

  // Engine datapath: CORDIC for sin/cos, then one multiply step
  always_comb begin
    ph_sum = {phase_two_input_ff[11], phase_two_input_ff}
      + {phase_three_input_ff[11], phase_three_input_ff};
    ph_diff = {phase_three_input_ff[11], phase_three_input_ff}
      - {phase_two_input_ff[11], phase_two_input_ff};
    y_prod = ph_diff * INV_SQRT3_Q14;
    dx = cx_ff >>> cnt_ff[3:0];
    dy = cy_ff >>> cnt_ff[3:0];
    case (quad_ff)
      2'b00: begin
        cos_v = cx_ff;
        sin_v = cy_ff;
      end
      2'b01: begin
        cos_v = -cy_ff;
        sin_v = cx_ff;
      end
      2'b10: begin
        cos_v = -cx_ff;
        sin_v = -cy_ff;
      end
      default: begin
        cos_v = cy_ff;
        sin_v = -cx_ff;
      end
    endcase
    // Forward rotates the other way: same products with sin negated
    if (mode_ff == VT_FWD) begin
      sin_v = -sin_v;
    end
    xc = wx_ff * cos_v;
    ys = wy_ff * sin_v;
    yc = wy_ff * cos_v;
    xs = wx_ff * sin_v;
    half_a = {{17{wa_ff[11]}}, wa_ff} <<< 13;
    k_b = wb_ff * HALF_SQRT3_Q14;
    finish = (mode_ff != VT_IDLE)
      && (cnt_ff == ((mode_ff == VT_FWD) ? FWD_CYC : REV_CYC) - 6'h01);

    nxt_mode = mode_ff;
    nxt_last_fwd = last_fwd_ff;
    nxt_cnt = cnt_ff + 6'h01;
    nxt_quad = quad_ff;
    nxt_cx = cx_ff;
    nxt_cy = cy_ff;
    nxt_cz = cz_ff;
    nxt_wx = wx_ff;
    nxt_wy = wy_ff;
    nxt_wa = wa_ff;
    nxt_wb = wb_ff;
    nxt_done = 1'b0;
    nxt_x_current_result = x_current_result_ff;
    nxt_y_current_result = y_current_result_ff;
    nxt_direct_current_result = direct_current_result_ff;
    nxt_quadrature_current_result = quadrature_current_result_ff;
    nxt_x_voltage_result = x_voltage_result_ff;
    nxt_y_voltage_result = y_voltage_result_ff;
    nxt_phase_two_output = phase_two_output_ff;
    nxt_phase_three_output = phase_three_output_ff;
    if (mode_ff == VT_IDLE) begin
      nxt_cnt = 6'h00;
      // A start while busy is dropped, so the two kinds never overlap
      if (wr_take && (lat_addr_ff == ADDR_REV_ANGLE || lat_addr_ff == ADDR_FWD_ANGLE)) begin
        nxt_quad = lat_data_ff[11:10];
        nxt_cx = CORDIC_K_Q14;
        nxt_cy = 16'sh0000;
        nxt_cz = {2'b00, lat_data_ff[9:0]};
        if (lat_addr_ff == ADDR_REV_ANGLE) begin
          nxt_mode = VT_REV;
          nxt_wx = ctrl_ff[CTRL_THREE_PHASE_BIT] ? phase_one_input_ff
            : sat12({{16{ph_sum[12]}}, ph_sum} * -29'sh0000001);
          nxt_wy = sat12(y_prod >>> 14);
        end else begin
          nxt_mode = VT_FWD;
          nxt_wx = direct_voltage_in;
          nxt_wy = quadrature_voltage_in;
        end
      end
    end else if (cnt_ff < CORDIC_ITER) begin
      if (cz_ff >= 12'sh000) begin
        nxt_cx = cx_ff - dy;
        nxt_cy = cy_ff + dx;
        nxt_cz = cz_ff - atan_step(cnt_ff[3:0]);
      end else begin
        nxt_cx = cx_ff + dy;
        nxt_cy = cy_ff - dx;
        nxt_cz = cz_ff + atan_step(cnt_ff[3:0]);
      end
    end else if (cnt_ff == CORDIC_ITER) begin
      // Signed on purpose: a bare concatenation would make the shift logical
      nxt_wa = sat12(($signed({xc[27], xc}) + $signed({ys[27], ys})) >>> 14);
      nxt_wb = sat12(($signed({yc[27], yc}) - $signed({xs[27], xs})) >>> 14);
    end else if (finish) begin
      nxt_mode = VT_IDLE;
      nxt_done = 1'b1;
      if (mode_ff == VT_REV) begin
        nxt_last_fwd = 1'b0;
        nxt_x_current_result = wx_ff;
        nxt_y_current_result = wy_ff;
        nxt_direct_current_result = wa_ff;
        nxt_quadrature_current_result = wb_ff;
      end else begin
        nxt_last_fwd = 1'b1;
        nxt_x_voltage_result = wa_ff;
        nxt_y_voltage_result = wb_ff;
        nxt_phase_two_output = sat12((-half_a - k_b) >>> 14);
        nxt_phase_three_output = sat12((-half_a + k_b) >>> 14);
      end
    end
    nxt_busy = nxt_mode != VT_IDLE;
  end

  // Interrupt flags; a new event in the read cycle survives the clear
  assign ev_adc = adc_done_i && ctrl_ff[CTRL_ADC_IRQ_EN_BIT];
  assign ev_vt = finish && ctrl_ff[CTRL_VT_IRQ_EN_BIT];
  assign ev_any = ev_adc || ev_vt;

  always_comb begin
    nxt_flags = flags_read ? 3'b000 : flags_ff;
    if (ev_any) begin
      nxt_flags[2] = 1'b1;
    end
    if (ev_vt) begin
      nxt_flags[1] = 1'b1;
    end
    if (ev_adc) begin
      nxt_flags[0] = 1'b1;
    end
    nxt_irq_hold = (irq_hold_ff && !flags_read) || ev_any;
    nxt_irq_oe = ctrl_ff[CTRL_LEVEL_MODE_BIT] ? nxt_irq_hold : ev_any;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst) begin
      wr_low_ff <= 1'b0;
      rd_low_ff <= 1'b0;
      rdata_oe_ff <= 1'b0;
      lat_addr_ff <= 4'h0;
      lat_data_ff <= 12'h000;
      rdata_ff <= 12'h000;
      ctrl_ff <= CTRL_RESET;
      phase_one_input_ff <= 12'sh000;
      phase_two_input_ff <= 12'sh000;
      phase_three_input_ff <= 12'sh000;
      mode_ff <= VT_IDLE;
      last_fwd_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= 6'h00;
      quad_ff <= 2'b00;
      cx_ff <= 16'sh0000;
      cy_ff <= 16'sh0000;
      cz_ff <= 12'sh000;
      wx_ff <= 12'sh000;
      wy_ff <= 12'sh000;
      wa_ff <= 12'sh000;
      wb_ff <= 12'sh000;
      x_current_result_ff <= 12'sh000;
      y_current_result_ff <= 12'sh000;
      direct_current_result_ff <= 12'sh000;
      quadrature_current_result_ff <= 12'sh000;
      x_voltage_result_ff <= 12'sh000;
      y_voltage_result_ff <= 12'sh000;
      phase_two_output_ff <= 12'sh000;
      phase_three_output_ff <= 12'sh000;
      flags_ff <= 3'b000;
      irq_hold_ff <= 1'b0;
      irq_oe_ff <= 1'b0;
    end else begin
      wr_low_ff <= nxt_wr_low;
      rd_low_ff <= nxt_rd_low;
      rdata_oe_ff <= nxt_rdata_oe;
      lat_addr_ff <= nxt_lat_addr;
      lat_data_ff <= nxt_lat_data;
      rdata_ff <= nxt_rdata;
      ctrl_ff <= nxt_ctrl;
      phase_one_input_ff <= nxt_phase_one_input;
      phase_two_input_ff <= nxt_phase_two_input;
      phase_three_input_ff <= nxt_phase_three_input;
      mode_ff <= nxt_mode;
      last_fwd_ff <= nxt_last_fwd;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      cnt_ff <= nxt_cnt;
      quad_ff <= nxt_quad;
      cx_ff <= nxt_cx;
      cy_ff <= nxt_cy;
      cz_ff <= nxt_cz;
      wx_ff <= nxt_wx;
      wy_ff <= nxt_wy;
      wa_ff <= nxt_wa;
      wb_ff <= nxt_wb;
      x_current_result_ff <= nxt_x_current_result;
      y_current_result_ff <= nxt_y_current_result;
      direct_current_result_ff <= nxt_direct_current_result;
      quadrature_current_result_ff <= nxt_quadrature_current_result;
      x_voltage_result_ff <= nxt_x_voltage_result;
      y_voltage_result_ff <= nxt_y_voltage_result;
      phase_two_output_ff <= nxt_phase_two_output;
      phase_three_output_ff <= nxt_phase_three_output;
      flags_ff <= nxt_flags;
      irq_hold_ff <= nxt_irq_hold;
      irq_oe_ff <= nxt_irq_oe;
    end
  end

  assign link.dev_data = rdata_ff;
  assign link.dev_data_oe = rdata_oe_ff;
  // Enable only; the line itself is never driven high
  assign link.irq_oe = irq_oe_ff;
  assign busy_o = busy_ff;
  assign vt_done_o = done_ff;
endmodule : vt_device
`default_nettype wire

// ===== design/vt_pkg.sv
`default_nettype none
package vt_pkg;
  // Write map of the parallel port
  localparam logic [3:0] ADDR_REV_ANGLE = 4'h0;
  localparam logic [3:0] ADDR_PH1_VD = 4'h1;
  localparam logic [3:0] ADDR_PH2_VQ = 4'h2;
  localparam logic [3:0] ADDR_PH3 = 4'h3;
  localparam logic [3:0] ADDR_FWD_ANGLE = 4'h4;
  localparam logic [3:0] ADDR_SYS_CTRL = 4'hd;
  // Read map
  localparam logic [3:0] ADDR_RES0 = 4'h0;
  localparam logic [3:0] ADDR_RES1 = 4'h1;
  localparam logic [3:0] ADDR_RES2 = 4'h2;
  localparam logic [3:0] ADDR_RES3 = 4'h3;
  localparam logic [3:0] ADDR_SYS_FLAGS = 4'hd;
  // Control and flag fields
  localparam int CTRL_THREE_PHASE_BIT = 10;
  localparam int CTRL_LEVEL_MODE_BIT = 8;
  localparam int CTRL_ADC_IRQ_EN_BIT = 7;
  localparam int CTRL_VT_IRQ_EN_BIT = 6;
  localparam int FLAG_ANY_BIT = 11;
  localparam int FLAG_VT_BIT = 1;
  localparam int FLAG_ADC_BIT = 0;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  // Timing, in system clock cycles (100 ns each)
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [5:0] REV_CYC = 6'h25;
  localparam logic [5:0] FWD_CYC = 6'h28;
  localparam logic [5:0] RESET_HOLD_CYC = 6'h02;
  localparam logic [5:0] CORDIC_ITER = 6'h0c;
  // Fixed point constants, Q14
  localparam logic signed [15:0] CORDIC_K_Q14 = 16'sh26dd;
  localparam logic signed [15:0] INV_SQRT3_Q14 = 16'sh24f3;
  localparam logic signed [15:0] HALF_SQRT3_Q14 = 16'sh376d;

  typedef enum logic [1:0] {
    VT_IDLE = 2'b00,
    VT_REV = 2'b01,
    VT_FWD = 2'b10
  } vt_mode_t;

  typedef enum logic [2:0] {
    H_RESET = 3'b000,
    H_IDLE = 3'b001,
    H_WR_LOW = 3'b010,
    H_WR_HIGH = 3'b011,
    H_RD1 = 3'b100,
    H_RD2 = 3'b101
  } host_state_t;

  // Arctangent of 2^-i, in units of a turn / 4096
  function automatic logic signed [11:0] atan_step(input logic [3:0] i);
    case (i)
      4'h0: atan_step = 12'sh200;
      4'h1: atan_step = 12'sh12e;
      4'h2: atan_step = 12'sh0a0;
      4'h3: atan_step = 12'sh051;
      4'h4: atan_step = 12'sh029;
      4'h5: atan_step = 12'sh014;
      4'h6: atan_step = 12'sh00a;
      4'h7: atan_step = 12'sh005;
      4'h8: atan_step = 12'sh003;
      4'h9: atan_step = 12'sh001;
      4'ha: atan_step = 12'sh001;
      default: atan_step = 12'sh000;
    endcase
  endfunction : atan_step

  function automatic logic signed [11:0] sat12(input logic signed [28:0] v);
    if (v > 29'sh00007ff) begin
      sat12 = 12'sh7ff;
    end else if (v < -29'sh0000800) begin
      sat12 = 12'sh800;
    end else begin
      sat12 = v[11:0];
    end
  endfunction : sat12
endpackage : vt_pkg
`default_nettype wire

// ===== design/vt_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface vt_port_if;
  logic dev_reset_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic [3:0] addr;
  logic [11:0] host_data;
  logic host_data_oe;
  logic [11:0] dev_data;
  logic dev_data_oe;
  logic irq_oe;
  logic [11:0] data_bus;
  logic irq_n;

  // Device drive wins; an undriven bus reads as zero
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 12'h000);
  // Open-drain line with external pull-up
  assign irq_n = ~irq_oe;

  modport device (
    input dev_reset_n, cs_n, rd_n, wr_n, addr, data_bus,
    output dev_data, dev_data_oe, irq_oe
  );
  modport host (
    output dev_reset_n, cs_n, rd_n, wr_n, addr, host_data, host_data_oe,
    input data_bus, irq_n
  );
endinterface : vt_port_if
`default_nettype wire

// ===== design/vt_host.sv
`timescale 1ns/10ps
`default_nettype none
module vt_host
  import vt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [3:0] addr_i,
  input wire logic [11:0] wdata_i,
  output logic ready_o,
  output logic [11:0] rdata_o,
  output logic rdata_valid_o,
  output logic irq_o,
  vt_port_if.host link
);
  host_state_t state_ff, nxt_state;
  logic [5:0] cnt_ff, nxt_cnt;
  logic cs_n_ff, nxt_cs_n, rd_n_ff, nxt_rd_n, wr_n_ff, nxt_wr_n;
  logic oe_ff, nxt_oe, rst_n_ff, nxt_rst_n, ready_ff, nxt_ready;
  logic valid_ff, nxt_valid, irq_ff;
  logic [3:0] addr_ff, nxt_addr;
  logic [11:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff != 6'h00) ? cnt_ff - 6'h01 : 6'h00;
    nxt_cs_n = cs_n_ff;
    nxt_rd_n = rd_n_ff;
    nxt_wr_n = wr_n_ff;
    nxt_oe = oe_ff;
    nxt_rst_n = rst_n_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_valid = 1'b0;
    case (state_ff)
      H_RESET: begin
        if (cnt_ff == 6'h00) begin
          nxt_rst_n = 1'b1;
          nxt_state = H_IDLE;
        end
      end
      H_IDLE: begin
        if (req_i && ready_ff) begin
          nxt_cs_n = 1'b0;
          nxt_addr = addr_i;
          nxt_wdata = wdata_i;
          if (we_i) begin
            nxt_wr_n = 1'b0;
            nxt_oe = 1'b1;
            nxt_state = H_WR_LOW;
            // Every port access waits FWD_CYC cycles after an angle write is accepted
            if (addr_i == ADDR_REV_ANGLE || addr_i == ADDR_FWD_ANGLE) begin
              nxt_cnt = FWD_CYC;
            end
          end else begin
            nxt_rd_n = 1'b0;
            nxt_state = H_RD1;
          end
        end
      end
      H_WR_LOW: begin
        nxt_wr_n = 1'b1;
        nxt_state = H_WR_HIGH;
      end
      H_WR_HIGH: begin
        nxt_cs_n = 1'b1;
        nxt_oe = 1'b0;
        nxt_state = H_IDLE;
      end
      H_RD1: nxt_state = H_RD2;
      H_RD2: begin
        nxt_rdata = link.data_bus;
        nxt_valid = 1'b1;
        nxt_cs_n = 1'b1;
        nxt_rd_n = 1'b1;
        nxt_state = H_IDLE;
      end
      default: nxt_state = H_IDLE;
    endcase
    nxt_ready = (nxt_state == H_IDLE) && (nxt_cnt == 6'h00);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_ff <= H_RESET;
      cnt_ff <= RESET_HOLD_CYC - 6'h01;
      cs_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      oe_ff <= 1'b0;
      rst_n_ff <= 1'b0;
      ready_ff <= 1'b0;
      valid_ff <= 1'b0;
      irq_ff <= 1'b0;
      addr_ff <= 4'h0;
      wdata_ff <= 12'h000;
      rdata_ff <= 12'h000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cs_n_ff <= nxt_cs_n;
      rd_n_ff <= nxt_rd_n;
      wr_n_ff <= nxt_wr_n;
      oe_ff <= nxt_oe;
      rst_n_ff <= nxt_rst_n;
      ready_ff <= nxt_ready;
      valid_ff <= nxt_valid;
      irq_ff <= ~link.irq_n;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
    end
  end

  assign link.dev_reset_n = rst_n_ff;
  assign link.cs_n = cs_n_ff;
  assign link.rd_n = rd_n_ff;
  assign link.wr_n = wr_n_ff;
  assign link.addr = addr_ff;
  assign link.host_data = wdata_ff;
  assign link.host_data_oe = oe_ff;
  assign ready_o = ready_ff;
  assign rdata_o = rdata_ff;
  assign rdata_valid_o = valid_ff;
  assign irq_o = irq_ff;
endmodule : vt_host
`default_nettype wire

// ===== test/vt_link_properties.sv
`timescale 1ns/10ps
`default_nettype none
module vt_link_properties
  import vt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic dev_reset_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [3:0] addr,
  input wire logic [11:0] data_bus,
  input wire logic dev_data_oe,
  input wire logic irq_oe
);
  logic dev_ok, commit, rd_first, wl_ff, rl_ff;
  logic [3:0] wa_ff, nxt_wa;
  logic [11:0] wd_ff, nxt_wd, ctrl_ff, nxt_ctrl;

  // Shadow of the write-only control word, needed to know the line mode
  always_comb begin
    dev_ok = reset_n_i && dev_reset_n;
    commit = wl_ff && wr_n && !cs_n;
    rd_first = !cs_n && !rd_n && !rl_ff;
    nxt_wa = (!cs_n && !wr_n) ? addr : wa_ff;
    nxt_wd = (!cs_n && !wr_n) ? data_bus : wd_ff;
    nxt_ctrl = (commit && wa_ff == ADDR_SYS_CTRL) ? wd_ff : ctrl_ff;
  end

  always_ff @(posedge clk_sys_i) begin
    wl_ff <= !cs_n && !wr_n;
    rl_ff <= !cs_n && !rd_n;
    wa_ff <= nxt_wa;
    wd_ff <= nxt_wd;
    ctrl_ff <= dev_ok ? nxt_ctrl : CTRL_RESET;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!dev_ok);

  sequence s_rev_start;
    commit && wa_ff == ADDR_REV_ANGLE && ctrl_ff[CTRL_VT_IRQ_EN_BIT] && !irq_oe;
  endsequence
  sequence s_fwd_start;
    commit && wa_ff == ADDR_FWD_ANGLE && ctrl_ff[CTRL_VT_IRQ_EN_BIT] && !irq_oe;
  endsequence
  sequence s_read_drive;
    dev_data_oe [*2] ##1 !dev_data_oe;
  endsequence

  a_reset_hold: assert property (disable iff (!reset_n_i)
    $rose(dev_reset_n) |-> !$past(dev_reset_n) && !$past(dev_reset_n, 2))
    else $error("device reset released too early");
  a_rev_done: assert property (s_rev_start |-> ##[37:38] $rose(irq_oe))
    else $error("reverse completion off time");
  a_fwd_done: assert property (s_fwd_start |-> ##[40:41] $rose(irq_oe))
    else $error("forward completion off time");
  a_irq_cause: assert property ($rose(irq_oe) |-> ctrl_ff[6] || ctrl_ff[7])
    else $error("request line pulled with sources disabled");
  a_edge_pulse: assert property (
    !ctrl_ff[CTRL_LEVEL_MODE_BIT] && $rose(irq_oe) |=> !irq_oe)
    else $error("edge mode pulse longer than one cycle");
  a_level_hold: assert property (
    ctrl_ff[CTRL_LEVEL_MODE_BIT] && irq_oe && !(rd_first && addr == ADDR_SYS_FLAGS)
    |=> irq_oe) else $error("level mode request dropped before flags read");
  a_read_answer: assert property (rd_first |=> s_read_drive)
    else $error("read data not driven for the read cycle");
  a_reset_quiet: assert property (disable iff (!reset_n_i)
    !dev_reset_n |=> !irq_oe && !dev_data_oe)
    else $error("device drives lines in reset");
endmodule : vt_link_properties
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic req_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [11:0] wdata_i = 12'h000;
  logic adc_done_i = 1'b0;
  logic ready_o, rdata_valid_o, irq_o, busy_o, vt_done_o;
  logic [11:0] rdata_o;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;

  vt_port_if u_vt_port_if ();
  vt_host u_vt_host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req_i),
    .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .irq_o(irq_o), .link(u_vt_port_if));
  vt_device u_vt_device (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .adc_done_i(adc_done_i), .busy_o(busy_o), .vt_done_o(vt_done_o), .link(u_vt_port_if));
  vt_link_properties u_vt_link_properties (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .dev_reset_n(u_vt_port_if.dev_reset_n), .cs_n(u_vt_port_if.cs_n),
    .rd_n(u_vt_port_if.rd_n), .wr_n(u_vt_port_if.wr_n), .addr(u_vt_port_if.addr),
    .data_bus(u_vt_port_if.data_bus), .dev_data_oe(u_vt_port_if.dev_data_oe),
    .irq_oe(u_vt_port_if.irq_oe));

  always #50 clk_sys_i = ~clk_sys_i;

  // Tests need well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // Tolerance covers the few LSB of sine and cosine error
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got,
                     input int tol);
    int d;
    checks_done++;
    d = int'($signed(got)) - int'($signed(exp));
    if ((^got) === 1'bx || d > tol || d < -tol) begin
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic acc(input logic w, input logic [3:0] a, input logic [11:0] d,
                     output logic [11:0] q);
    int n;
    @(posedge clk_sys_i);
    while (ready_o !== 1'b1) @(posedge clk_sys_i);
    req_i <= 1'b1;
    we_i <= w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    for (n = 0; n < 20 && !w && rdata_valid_o !== 1'b1; n++) @(posedge clk_sys_i);
    q = rdata_o;
  endtask : acc

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    logic [11:0] q;
    acc(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [11:0] e,
                        input int tol);
    logic [11:0] q;
    acc(1'b0, a, 12'h000, q);
    chk(what, e, q, tol);
  endtask : rd_chk

  task automatic wait_irq();
    int n;
    for (n = 0; n < 100 && irq_o !== 1'b1; n++) @(posedge clk_sys_i);
  endtask : wait_irq

  // Edges from the angle write's acceptance: two to commit, one to see the pulse
  task automatic wait_done(input string what, input logic [5:0] cyc_exp);
    int n;
    n = 0;
    while (vt_done_o !== 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
      if (n == 3) begin
        chk({what, " busy"}, 12'h001, {11'h000, busy_o}, 0);
      end
    end
    chk(what, 12'(cyc_exp) + 12'h003, 12'(n), 0);
    chk({what, " idle"}, 12'h000, {11'h000, busy_o}, 0);
  endtask : wait_done

  task automatic adc_pulse();
    // The control write commits two edges after it is accepted
    repeat (3) @(posedge clk_sys_i);
    adc_done_i <= 1'b1;
    @(posedge clk_sys_i);
    adc_done_i <= 1'b0;
  endtask : adc_pulse

  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd_chk("flags after reset", ADDR_SYS_FLAGS, 12'h000, 0);
    rd_chk("unmapped read", 4'h5, 12'h000, 0);
    $display("test reset done");
    // Reverse, two-of-three mode, 90 degrees, edge mode
    wr(ADDR_SYS_CTRL, 12'h040);
    wr(ADDR_PH2_VQ, 12'h100);
    wr(ADDR_PH3, 12'h100);
    wr(ADDR_REV_ANGLE, 12'h400);
    wait_done("reverse cycles", REV_CYC);
    wait_irq();
    chk("irq after reverse", 12'h001, {11'h000, irq_o}, 0);
    @(posedge clk_sys_i);
    chk("edge pulse end", 12'h000, {11'h000, irq_o}, 0);
    rd_chk("flags reverse", ADDR_SYS_FLAGS, 12'h802, 0);
    rd_chk("flags cleared", ADDR_SYS_FLAGS, 12'h000, 0);
    rd_chk("x current", ADDR_RES2, 12'he00, 0);
    rd_chk("y current", ADDR_RES3, 12'h000, 0);
    rd_chk("direct current", ADDR_RES0, 12'h000, 6);
    rd_chk("quadrature current", ADDR_RES1, 12'h200, 6);
    rd_chk("x current again", ADDR_RES2, 12'he00, 0);
    $display("test reverse done");
    // Forward, three-phase, 90 degrees, level mode
    wr(ADDR_SYS_CTRL, 12'h540);
    wr(ADDR_PH1_VD, 12'h190);
    wr(ADDR_PH2_VQ, 12'h000);
    wr(ADDR_FWD_ANGLE, 12'h400);
    wait_done("forward cycles", FWD_CYC);
    wait_irq();
    repeat (5) @(posedge clk_sys_i);
    chk("level held", 12'h001, {11'h000, irq_o}, 0);
    rd_chk("flags forward", ADDR_SYS_FLAGS, 12'h802, 0);
    chk("level released", 12'h000, {11'h000, irq_o}, 0);
    rd_chk("phase one", ADDR_RES0, 12'h000, 6);
    rd_chk("phase two", ADDR_RES1, 12'hea6, 6);
    rd_chk("phase three", ADDR_RES2, 12'h15a, 6);
    rd_chk("y voltage", ADDR_RES3, 12'h190, 6);
    // Reverse in three-phase mode, angle zero, line still in level mode
    wr(ADDR_PH1_VD, 12'h100);
    wr(ADDR_PH2_VQ, 12'h000);
    wr(ADDR_PH3, 12'h000);
    wr(ADDR_REV_ANGLE, 12'h000);
    wait_done("reverse three-phase", REV_CYC);
    rd_chk("flags three-phase", ADDR_SYS_FLAGS, 12'h802, 0);
    rd_chk("x current three-phase", ADDR_RES2, 12'h100, 0);
    rd_chk("direct current three-phase", ADDR_RES0, 12'h100, 6);
    $display("test forward done");
    // Conversion source enabled, then disabled
    wr(ADDR_SYS_CTRL, 12'h080);
    adc_pulse();
    wait_irq();
    rd_chk("flags conversion", ADDR_SYS_FLAGS, 12'h801, 0);
    wr(ADDR_SYS_CTRL, 12'h000);
    adc_pulse();
    repeat (5) @(posedge clk_sys_i);
    chk("irq disabled", 12'h000, {11'h000, irq_o}, 0);
    rd_chk("flags disabled", ADDR_SYS_FLAGS, 12'h000, 0);
    $display("test interrupt done");
    test_done();
  end
endmodule : tb
`default_nettype wire
